// File: verilog/sapc_device.sv
// Converter end: frame control, power mode and serial result shifting.
// Assumes frame select and shift clock come from the host as pins.
`timescale 1ns/1ns
module sapc_device #(
  parameter int RES_W = sapc_pkg::RESULT_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  sapc_if.dev link,
  input wire logic [RES_W-1:0] i_sample,
  input wire logic i_powerup_shutdown,
  output logic o_shutdown,
  output logic o_powered,
  output logic o_tracking,
  output logic o_sample_taken,
  output logic [RES_W-1:0] o_held_sample
);
  initial begin
    if (RES_W != sapc_pkg::RESULT_BITS) begin
      $error("sapc_device supports only the documented result width");
    end
  end

  // -----------------------------------------------------------------
  // Pin synchronisation
  // -----------------------------------------------------------------
  logic sel_b_s;
  logic sclk_s;
  logic sel_b_d_reg;
  logic sclk_d_reg;

  sapc_sync u_sel_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_rst_val(1'b1),
    .i_pin(link.frame_sel_b),
    .o_level(sel_b_s)
  );
  sapc_sync u_sclk_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_rst_val(1'b1),
    .i_pin(link.shift_clk),
    .o_level(sclk_s)
  );

  // Delayed copies for edge detection of the synchronised levels.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sel_b_d_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
    end else begin
      sel_b_d_reg <= sel_b_s;
      sclk_d_reg <= sclk_s;
    end
  end

  // Edge events of the link.
  wire sel_fall = sel_b_d_reg & ~sel_b_s;
  wire sel_rise = ~sel_b_d_reg & sel_b_s;
  wire sclk_fall = sclk_d_reg & ~sclk_s;
  wire sclk_rise = ~sclk_d_reg & sclk_s;

  // -----------------------------------------------------------------
  // Frame state
  // -----------------------------------------------------------------
  logic [4:0] fall_cnt_reg;
  logic [4:0] rise_cnt_reg;
  logic in_frame_reg;
  logic drive_reg;
  logic shutdown_reg;
  logic waking_reg;
  logic dummy_reg;
  logic [4:0] pwr_cnt_reg;
  logic powered_reg;
  logic [RES_W-1:0] held_reg;
  logic data_reg;
  logic mode_seen_reg;

  // Outcome decode on a select rise, from the fall count.
  wire early_rise = fall_cnt_reg < 5'(sapc_pkg::SHUTDOWN_LO_FALL);
  wire sd_rise = !early_rise && (fall_cnt_reg < 5'(sapc_pkg::SHUTDOWN_HI_FALL));
  wire word_done = fall_cnt_reg >= 5'(sapc_pkg::FRAME_FALLS);
  wire abort_rise = !sd_rise && !early_rise && !word_done;
  // A waking device drops back on any raise before fall ten.
  wire wake_fail = waking_reg && (fall_cnt_reg < 5'(sapc_pkg::SHUTDOWN_HI_FALL));

  // Bit index picked on a fall: 3 zeros, 10 result bits, 3 zeros.
  wire [4:0] bit_pos = fall_cnt_reg;
  wire in_data = (bit_pos >= 5'(sapc_pkg::LEAD_ZEROS - 1)) &&
                 (bit_pos < 5'(sapc_pkg::LEAD_ZEROS + RES_W - 1));
  wire [4:0] data_idx = 5'(sapc_pkg::LEAD_ZEROS + RES_W - 2) - bit_pos;
  wire next_bit = in_data ? held_reg[data_idx[3:0]] : 1'b0;

  // Counter and frame flags; the shift clock falls are counted per frame.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      fall_cnt_reg <= 5'h00;
      rise_cnt_reg <= 5'h00;
      in_frame_reg <= 1'b0;
    end else if (sel_fall) begin
      fall_cnt_reg <= 5'h00;
      rise_cnt_reg <= 5'h00;
      in_frame_reg <= 1'b1;
    end else if (sel_rise) begin
      in_frame_reg <= 1'b0;
    end else if (in_frame_reg) begin
      if (sclk_fall && fall_cnt_reg != 5'h1f) begin
        fall_cnt_reg <= fall_cnt_reg + 5'h01;
      end
      if (sclk_rise && rise_cnt_reg != 5'h1f) begin
        rise_cnt_reg <= rise_cnt_reg + 5'h01;
      end
    end
  end

  // Output drive and data shifting; released at fall 16 or on select rise.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      drive_reg <= 1'b0;
      data_reg <= 1'b0;
    end else if (sel_fall) begin
      drive_reg <= 1'b1;
      data_reg <= 1'b0;
    end else if (sel_rise) begin
      drive_reg <= 1'b0;
    end else if (in_frame_reg && sclk_fall) begin
      if (fall_cnt_reg == 5'(sapc_pkg::FRAME_FALLS - 1)) begin
        drive_reg <= 1'b0;
      end
      data_reg <= next_bit;
    end
  end

  // Sample capture at select fall; a dummy frame yields zero.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      held_reg <= '0;
    end else if (sel_fall) begin
      held_reg <= (shutdown_reg || !powered_reg) ? sapc_pkg::DUMMY_RESULT : i_sample;
    end
  end

  // Power mode. The start-up mode is caught by a clocked step after reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      shutdown_reg <= 1'b0;
      waking_reg <= 1'b0;
      dummy_reg <= 1'b0;
      mode_seen_reg <= 1'b0;
    end else if (!mode_seen_reg) begin
      mode_seen_reg <= 1'b1;
      shutdown_reg <= i_powerup_shutdown;
      dummy_reg <= 1'b1;
    end else if (sel_fall) begin
      waking_reg <= shutdown_reg;
      dummy_reg <= shutdown_reg || !powered_reg;
      shutdown_reg <= 1'b0;
    end else if (sel_rise) begin
      waking_reg <= 1'b0;
      if (wake_fail || sd_rise) begin
        shutdown_reg <= 1'b1;
      end else if (early_rise || abort_rise) begin
        shutdown_reg <= 1'b0;
      end
    end
  end

  // Power-up counter: full power after sixteen shift clocks awake.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pwr_cnt_reg <= 5'h00;
      powered_reg <= 1'b0;
    end else if (shutdown_reg) begin
      pwr_cnt_reg <= 5'h00;
      powered_reg <= 1'b0;
    end else if (sclk_fall && !powered_reg) begin
      if (pwr_cnt_reg == 5'(sapc_pkg::POWERUP_SCLKS - 1)) begin
        powered_reg <= 1'b1;
      end
      pwr_cnt_reg <= pwr_cnt_reg + 5'h01;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign link.serial_result_out = data_reg;
  assign link.serial_result_oe = drive_reg;
  assign o_shutdown = shutdown_reg;
  assign o_powered = powered_reg;
  // Track once rise 13 passes, or whenever no frame is open.
  assign o_tracking = !in_frame_reg || (rise_cnt_reg >= 5'(sapc_pkg::TRACK_RISE));
  assign o_sample_taken = in_frame_reg && dummy_reg == 1'b0 && fall_cnt_reg == 5'h00;
  assign o_held_sample = held_reg;
endmodule

// File: common/sapc_pkg.sv
// Shared constants for the serial converter frame and power-mode control.
// Assumes both ends run on one system clock; the link pins are sampled logic.
package sapc_pkg;
  // -----------------------------------------------------------------
  // Frame geometry
  // -----------------------------------------------------------------
  localparam int RESULT_BITS = 10;
  localparam int LEAD_ZEROS = 3;
  localparam int FRAME_FALLS = 16;
  localparam int SHUTDOWN_LO_FALL = 2;
  localparam int SHUTDOWN_HI_FALL = 10;
  localparam int TRACK_RISE = 13;
  localparam int FRAME_SCLKS = 20;
  localparam int POWERUP_SCLKS = 16;
  localparam int EARLY_RAISE_FALL = 12;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACQ_INTERVAL_NS = 350;
  localparam int ACQ_CYCLES = (ACQ_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_INTERVAL_NS = 50;
  localparam int QUIET_CYCLES = (QUIET_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF = 2;
  localparam logic [9:0] DUMMY_RESULT = 10'h000;
  typedef enum {
    SAPC_NORMAL,
    SAPC_SHUTDOWN
  } sapc_mode_type;
endpackage

// File: common/sapc_if.sv
// Serial link between the converter end and the host end.
// The wire level of the serial result is resolved here from its enable.
`timescale 1ns/1ns
interface sapc_if;
  logic frame_sel_b;
  logic shift_clk;
  logic serial_result_out;
  logic serial_result_oe;
  logic serial_result_in;

  // Undriven line reads as a plain driven zero seen by the host.
  assign serial_result_in = serial_result_oe ? serial_result_out : 1'b0;

  modport dev (
    input frame_sel_b,
    input shift_clk,
    output serial_result_out,
    output serial_result_oe
  );
  modport host (
    output frame_sel_b,
    output shift_clk,
    input serial_result_in,
    input serial_result_oe
  );
endinterface

// File: verilog/sapc_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the input comes from outside the clock domain.
`timescale 1ns/1ns
module sapc_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_rst_val,
  input wire logic i_pin,
  output logic o_level
);
  logic meta_reg;

  // The first stage feeds only the second stage.
  // Both stages reset to the pin's idle level, so no false edge follows reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_reg <= i_rst_val;
      o_level <= i_rst_val;
    end else begin
      meta_reg <= i_pin;
      o_level <= meta_reg;
    end
  end
endmodule

// File: verilog/sapc_host.sv
// Host end: frames conversions, gives quiet time, discards the dummy word.
// Assumes the link is joined to the device end by the testbench.
`timescale 1ns/1ns
module sapc_host #(
  parameter int RES_W = sapc_pkg::RESULT_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  sapc_if.host link,
  input wire logic i_start,
  input wire logic i_sleep,
  output logic o_busy,
  output logic o_valid,
  output logic [RES_W-1:0] o_result
);
  initial begin
    if (RES_W != sapc_pkg::RESULT_BITS) begin
      $error("sapc_host supports only the documented result width");
    end
  end

  typedef enum {
    H_IDLE,
    H_FRAME,
    H_QUIET
  } sapc_hstate_type;

  sapc_hstate_type state_reg;
  logic [5:0] half_reg;
  logic [1:0] div_reg;
  logic [3:0] wait_reg;
  logic [15:0] shift_reg;
  logic sleep_reg;
  logic need_dummy_reg;
  logic sdo_m_reg;
  logic sdo_s_reg;

  // Frame length in half periods: full 20 clocks, or raise after fall 12.
  wire [5:0] last_half = sleep_reg ? 6'(2 * sapc_pkg::EARLY_RAISE_FALL) :
                                     6'(2 * sapc_pkg::FRAME_SCLKS);
  wire tick = div_reg == 2'(sapc_pkg::SCLK_HALF - 1);
  wire wait_len_ok = wait_reg >= 4'(sapc_pkg::ACQ_CYCLES + sapc_pkg::QUIET_CYCLES);

  // Result pin passes two flops before use.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sdo_m_reg <= 1'b0;
      sdo_s_reg <= 1'b0;
    end else begin
      sdo_m_reg <= link.serial_result_in;
      sdo_s_reg <= sdo_m_reg;
    end
  end

  // Frame sequencer; clock idles high so each fall is a whole edge.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg <= H_IDLE;
      half_reg <= 6'h00;
      div_reg <= 2'h0;
      wait_reg <= 4'h0;
      shift_reg <= 16'h0000;
      sleep_reg <= 1'b0;
      need_dummy_reg <= 1'b1;
      o_valid <= 1'b0;
      o_result <= '0;
    end else begin
      o_valid <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (i_start) begin
            state_reg <= H_FRAME;
            half_reg <= 6'h00;
            div_reg <= 2'h0;
            sleep_reg <= i_sleep;
          end
        end
        H_FRAME: begin
          div_reg <= tick ? 2'h0 : div_reg + 2'h1;
          if (tick) begin
            half_reg <= half_reg + 6'h01;
            // Sample on falls 2 to 17, two falls behind the data.
            if (half_reg[0] == 1'b0 && half_reg != 6'h00 &&
                half_reg <= 6'(2 * sapc_pkg::FRAME_FALLS)) begin
              shift_reg <= {shift_reg[14:0], sdo_s_reg};
            end
            if (half_reg == last_half - 6'h01) begin
              state_reg <= H_QUIET;
              wait_reg <= 4'h0;
            end
          end
        end
        H_QUIET: begin
          if (wait_len_ok) begin
            state_reg <= H_IDLE;
            // Dummy frames after wake or start-up are dropped.
            if (!sleep_reg && !need_dummy_reg) begin
              o_valid <= 1'b1;
              // Sample one is the zero shown at the select fall.
              o_result <= shift_reg[15 - sapc_pkg::LEAD_ZEROS -: RES_W];
            end
            need_dummy_reg <= sleep_reg;
          end else begin
            wait_reg <= wait_reg + 4'h1;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Select is low through the frame; the clock toggles only inside it.
  assign link.frame_sel_b = state_reg != H_FRAME;
  assign link.shift_clk = (state_reg != H_FRAME) || !half_reg[0];
  assign o_busy = state_reg != H_IDLE;
endmodule

// File: tb/sapc_link_sva.sv
// Link checker: framing, output enable and data zeros on the serial link.
// Assumes it sits beside the interface and shares the system clock and reset.
`timescale 1ns/1ns
module sapc_link_sva (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic frame_sel_b,
  input wire logic shift_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  int fall_cnt_reg;
  int high_cnt_reg;
  logic sclk_q_reg;
  logic sel_q_reg;
  // The idle count starts saturated, so the first frame after reset needs no gap.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      fall_cnt_reg <= 0;
      high_cnt_reg <= 1000;
      sclk_q_reg <= 1'b1;
      sel_q_reg <= 1'b1;
    end else begin
      sclk_q_reg <= shift_clk;
      sel_q_reg <= frame_sel_b;
      if (sel_q_reg && !frame_sel_b) begin
        fall_cnt_reg <= 0;
      end else if (sclk_q_reg && !shift_clk) begin
        fall_cnt_reg <= fall_cnt_reg + 1;
      end
      if (!frame_sel_b) begin
        high_cnt_reg <= 0;
      end else if (high_cnt_reg < 1000) begin
        high_cnt_reg <= high_cnt_reg + 1;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // The count lags the pin by one cycle and leads the device by two, so bounds are loose.
  property p_lead_zeros;
    @(posedge i_clk) disable iff (!i_rst_b)
      serial_result_oe && fall_cnt_reg <= 2 |-> !serial_result_out;
  endproperty
  a_lead_zeros: assert property (p_lead_zeros) else $error("leading bit not zero");
  property p_trail_zeros;
    @(posedge i_clk) disable iff (!i_rst_b)
      serial_result_oe && fall_cnt_reg == 14 |-> !serial_result_out;
  endproperty
  a_trail_zeros: assert property (p_trail_zeros) else $error("trailing bit not zero");
  property p_oe_on;
    @(posedge i_clk) disable iff (!i_rst_b)
      $fell(frame_sel_b) |-> ##[1:4] serial_result_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven after select");
  property p_oe_off_rise;
    @(posedge i_clk) disable iff (!i_rst_b)
      $rose(frame_sel_b) |-> ##[0:4] !serial_result_oe;
  endproperty
  a_oe_off_rise: assert property (p_oe_off_rise) else $error("output kept after rise");
  property p_oe_off_16;
    @(posedge i_clk) disable iff (!i_rst_b)
      !frame_sel_b && fall_cnt_reg > 16 |-> !serial_result_oe;
  endproperty
  a_oe_off_16: assert property (p_oe_off_16) else $error("output kept past word");
  property p_quiet_gap;
    @(posedge i_clk) disable iff (!i_rst_b)
      $fell(frame_sel_b) |-> high_cnt_reg >= sapc_pkg::QUIET_CYCLES;
  endproperty
  a_quiet_gap: assert property (p_quiet_gap) else $error("frames too close");
  property p_rise_late;
    @(posedge i_clk) disable iff (!i_rst_b)
      $rose(frame_sel_b) |-> fall_cnt_reg >= sapc_pkg::SHUTDOWN_HI_FALL;
  endproperty
  a_rise_late: assert property (p_rise_late) else $error("select raised too early");
  property p_sclk_half;
    @(posedge i_clk) disable iff (!i_rst_b)
      $fell(shift_clk) |-> ##1 !shift_clk ##1 shift_clk;
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("shift clock low phase wrong");
  property p_sclk_framed;
    @(posedge i_clk) disable iff (!i_rst_b)
      $fell(shift_clk) |-> !frame_sel_b;
  endproperty
  a_sclk_framed: assert property (p_sclk_framed) else $error("clock outside frame");
endmodule

// File: tb/serial_adc_frame_power_control_tb.sv
// Testbench: host and converter ends joined over the link, with a result model.
// Assumes the package, interface and design files are compiled before this one.
`timescale 1ns/1ns
module serial_adc_frame_power_control_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_clk;
  logic i_rst_b;
  logic i_start;
  logic i_sleep;
  logic i_powerup_shutdown;
  logic [9:0] i_sample;
  logic o_shutdown;
  logic o_powered;
  logic o_busy;
  logic o_valid;
  logic [9:0] o_result;
  logic [9:0] o_held_sample;
  logic o_tracking;
  logic o_sample_taken;
  int fails;
  int check_count;
  int seed;
  int exp_q[$];
  sapc_if link();
  sapc_device u_sapc_device (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link),
    .i_sample(i_sample), .i_powerup_shutdown(i_powerup_shutdown), .o_shutdown(o_shutdown),
    .o_powered(o_powered), .o_tracking(o_tracking), .o_sample_taken(o_sample_taken),
    .o_held_sample(o_held_sample));
  sapc_host u_sapc_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link), .i_start(i_start),
    .i_sleep(i_sleep), .o_busy(o_busy), .o_valid(o_valid), .o_result(o_result));
  sapc_link_sva u_sapc_link_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .frame_sel_b(link.frame_sel_b), .shift_clk(link.shift_clk),
    .serial_result_out(link.serial_result_out), .serial_result_oe(link.serial_result_oe));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compares with case inequality, so an unknown never passes.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One frame; a second start mid-frame must be refused, giving at most one word.
  task automatic run_frame(input logic sleep, input logic chk, input logic exp_valid);
    logic [9:0] smp;
    logic dmy;
    int nv;
    int idle;
    int n;
    smp = 10'($random(seed));
    nv = 0;
    idle = 0;
    // A frame whose word count is checked and expected empty is a dummy frame.
    dmy = chk && !exp_valid;
    exp_q.push_back(smp);
    @(negedge i_clk);
    i_sample = smp;
    i_sleep = sleep;
    i_start = 1'b1;
    for (n = 0; n < 300; n++) begin
      @(negedge i_clk);
      i_start = (n == 10);
      if (n == 3) check(o_sample_taken, !dmy);
      if (n == 50) check(o_tracking, 1'b0);
      if (n == 60) check(o_tracking, 1'b1);
      if (o_valid === 1'b1) begin
        nv++;
        if (exp_q.size() > 0) check(o_result, exp_q.pop_front());
      end
      idle = (o_busy === 1'b0) ? idle + 1 : 0;
      if (n > 12 && idle > 3) break;
    end
    if (n == 300) begin
      fails++;
      give_verdict();
    end
    exp_q.delete();
    if (chk) check(nv, exp_valid);
    check(o_held_sample, dmy ? sapc_pkg::DUMMY_RESULT : smp);
    check(o_shutdown, 1'b0);
    check(o_powered, 1'b1);
  endtask
  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // Starts in shutdown, wakes, runs random frames, then resets again in normal mode.
  initial begin
    logic sl;
    logic prev_sleep;
    seed = 32'ha35e;
    fails = 0;
    check_count = 0;
    i_rst_b = 1'b0;
    i_start = 1'b0;
    i_sleep = 1'b0;
    i_sample = 10'h000;
    i_powerup_shutdown = 1'b1;
    repeat (12) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (20) @(negedge i_clk);
    check(o_shutdown, 1'b1);
    run_frame(1'b0, 1'b1, 1'b0);
    prev_sleep = 1'b0;
    for (int i = 0; i < 12; i++) begin
      sl = (i == 3) || (($random(seed) & 3) == 0);
      run_frame(sl, !sl && !prev_sleep, 1'b1);
      prev_sleep = sl;
    end
    @(negedge i_clk);
    i_rst_b = 1'b0;
    i_powerup_shutdown = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    check(o_shutdown, 1'b0);
    run_frame(1'b0, 1'b1, 1'b0);
    run_frame(1'b0, 1'b1, 1'b1);
    give_verdict();
  end
endmodule
